// File: hw/fds_device.sv
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "fds_regs.svh"
module fds_device (
   input wire logic hclk,
   input wire logic hresetn,
   fds_if.device link,
   input wire logic [23:0] short_detect,
   input wire logic reference_current_pin_low,
   input wire logic reference_current_pin_high,
   input wire logic thermal_warn,
   input wire logic thermal_shutdown,
   output logic outputs_enable,
   output logic current_default,
   output logic short_test_active,
   output logic short_test_current_sel
);
   // Two-stage synchronisers for every pin and analog indication
   logic [2:0] link_meta;   // sck, sdi, latch first stage
   logic [2:0] link_sync;   // Second stage
   logic sck_prev;          // Edge detector on synced sck
   logic latch_prev;        // Edge detector on synced latch
   logic [27:0] ind_meta;   // Short vector plus four indications
   logic [27:0] ind_sync;
   logic [`FDS_FRAME_BITS-1:0] shift_reg; // Common shift register
   logic short_check_current_sel;  // Test current select
   logic short_check_time_sel;     // Detection interval select
   logic [2:0] short_check_result_code;
   logic [23:0] adjacent_short_result;
   logic ref_short_flag;
   logic ref_open_flag;
   logic thermal_warning_flag;
   logic thermal_error_flag;
   fds_pkg::fds_sc_state_t sc_state;
   logic [9:0] sc_timer;    // Counts the detection interval
   logic sck_rise;
   logic latch_rise;
   logic [11:0] cmd_code;
   logic cmd_clear;
   logic cmd_check;
   logic cmd_read;
   logic cmd_config;
   logic [23:0] short_now;  // Synced comparator vector
   logic open_now;
   logic short_ref_now;
   logic warn_now;
   logic therm_now;
   logic fault_any;

   // Pack the status word that a read or clear command shifts out
   function automatic logic [`FDS_ST_WIDTH-1:0] status_word(
      input logic [23:0] res,
      input logic [2:0] code,
      input logic rs,
      input logic ro,
      input logic tw,
      input logic te
   );
      logic [`FDS_ST_WIDTH-1:0] w;
      w = '0;
      w[`FDS_ST_RESULT_LSB +: 24] = res;
      w[`FDS_ST_CODE_LSB +: 3] = code;
      w[`FDS_ST_REF_SHORT_BIT] = rs;
      w[`FDS_ST_REF_OPEN_BIT] = ro;
      w[`FDS_ST_WARN_BIT] = tw;
      w[`FDS_ST_THERM_BIT] = te;
      return w;
   endfunction

   // Link pin synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_meta <= 3'h0;
         link_sync <= 3'h0;
         sck_prev <= 1'b0;
         latch_prev <= 1'b0;
      end else begin
         link_meta <= {link.latch, link.sdi, link.sck};
         link_sync <= link_meta;
         sck_prev <= link_sync[0];
         latch_prev <= link_sync[2];
      end
   end

   // Indication synchroniser, analog comparators are asynchronous
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ind_meta <= 28'h0000000;
         ind_sync <= 28'h0000000;
      end else begin
         ind_meta <= {thermal_shutdown, thermal_warn, reference_current_pin_high, reference_current_pin_low, short_detect};
         ind_sync <= ind_meta;
      end
   end

   assign short_now = ind_sync[23:0];
   // Open only when not also above the short threshold
   assign open_now = ind_sync[24] & ~ind_sync[25];
   assign short_ref_now = ind_sync[25];
   assign warn_now = ind_sync[26];
   assign therm_now = ind_sync[27];

   assign sck_rise = link_sync[0] & ~sck_prev;
   assign latch_rise = link_sync[2] & ~latch_prev;
   assign cmd_code = shift_reg[`FDS_CMD_MSB:`FDS_CMD_LSB];
   assign cmd_clear = latch_rise && (cmd_code == `FDS_CMD_FAULT_CLEAR);
   assign cmd_check = latch_rise && (cmd_code == `FDS_CMD_SHORT_CHECK);
   assign cmd_read = latch_rise && (cmd_code == `FDS_CMD_STATUS_READ);
   assign cmd_config = latch_rise && (cmd_code == `FDS_CMD_CONFIG);

   // Shift register keeps running in every thermal state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_reg <= '0;
         link.sdo <= 1'b0;
      end else begin
         if (cmd_clear || cmd_read) begin
            // Status snapshot taken before the clear acts
            shift_reg <= {{(`FDS_FRAME_BITS-`FDS_ST_WIDTH){1'b0}},
               status_word(adjacent_short_result, short_check_result_code,
               ref_short_flag, ref_open_flag, thermal_warning_flag,
               thermal_error_flag)};
         end else if (sck_rise) begin
            shift_reg <= {shift_reg[`FDS_FRAME_BITS-2:0], link_sync[1]};
         end
         link.sdo <= shift_reg[`FDS_FRAME_BITS-1];
      end
   end

   // Configuration frame loads the two check settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         short_check_current_sel <= 1'b0;
         short_check_time_sel <= 1'b0;
      end else if (cmd_config) begin
         short_check_current_sel <= shift_reg[`FDS_CFG_CUR_BIT];
         short_check_time_sel <= shift_reg[`FDS_CFG_TIME_BIT];
      end
   end

   // Short check sequencer, a new command during a check is ignored
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sc_state <= fds_pkg::FDS_SC_IDLE;
         sc_timer <= 10'h000;
      end else begin
         unique case (sc_state)
            fds_pkg::FDS_SC_IDLE: begin
               if (cmd_check) begin
                  sc_state <= fds_pkg::FDS_SC_RUN;
                  sc_timer <= short_check_time_sel ? 10'(`FDS_SC_CYC_LONG - 1)
                     : 10'(`FDS_SC_CYC_SHORT - 1);
               end
            end
            fds_pkg::FDS_SC_RUN: begin
               if (sc_timer == 10'h000) begin
                  sc_state <= fds_pkg::FDS_SC_LATCH;
               end else begin
                  sc_timer <= sc_timer - 10'h001;
               end
            end
            fds_pkg::FDS_SC_LATCH: begin
               sc_state <= fds_pkg::FDS_SC_IDLE;
            end
         endcase
      end
   end

   // Result code and vector; a latch in the clear cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         short_check_result_code <= `FDS_CODE_RESET;
         adjacent_short_result <= `FDS_RESULT_RESET;
      end else if (sc_state == fds_pkg::FDS_SC_LATCH) begin
         if (short_now == 24'h000000) begin
            short_check_result_code <= `FDS_CODE_PASS;
         end else begin
            short_check_result_code <= `FDS_CODE_FAIL;
         end
         // Bit i is output i of the fixed red, pin, blue order
         adjacent_short_result <= short_now;
      end else if (cmd_clear && short_now == 24'h000000) begin
         // Fail code held until the short is gone
         short_check_result_code <= `FDS_CODE_NONE;
         adjacent_short_result <= `FDS_RESULT_RESET;
      end
   end

   // Reference flags: set wins over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_short_flag <= 1'b0;
         ref_open_flag <= 1'b0;
      end else begin
         if (short_ref_now) begin
            ref_short_flag <= 1'b1;
         end else if (cmd_clear) begin
            ref_short_flag <= 1'b0;
         end
         if (open_now) begin
            ref_open_flag <= 1'b1;
         end else if (cmd_clear) begin
            ref_open_flag <= 1'b0;
         end
      end
   end

   // Thermal flags, cleared only by the clear command once cool
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         thermal_warning_flag <= 1'b0;
         thermal_error_flag <= 1'b0;
      end else begin
         if (warn_now) begin
            thermal_warning_flag <= 1'b1;
         end else if (cmd_clear) begin
            thermal_warning_flag <= 1'b0;
         end
         if (therm_now) begin
            thermal_error_flag <= 1'b1;
         end else if (cmd_clear) begin
            thermal_error_flag <= 1'b0;
         end
      end
   end

   // Analog side controls, registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         outputs_enable <= 1'b0;
         current_default <= 1'b0;
         short_test_active <= 1'b0;
         short_test_current_sel <= 1'b0;
      end else begin
         // Follows the live condition, not the latched flag
         outputs_enable <= ~therm_now;
         // Returns to programmed current as soon as the fault goes
         current_default <= open_now | short_ref_now;
         short_test_active <= (sc_state == fds_pkg::FDS_SC_RUN);
         short_test_current_sel <= short_check_current_sel;
      end
   end

   // Fault pulldown straight from the latched flags, no extra delay
   assign fault_any = (short_check_result_code == `FDS_CODE_FAIL) | ref_short_flag
      | ref_open_flag | thermal_warning_flag | thermal_error_flag;
   assign link.err_o = 1'b0;
   assign link.err_oe_n = ~fault_any;
endmodule

// File: hw/fds_host.sv
`timescale 1ns/1ps
`include "fds_regs.svh"
module fds_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   fds_if.host link
);
   logic ap_write;   // Registered write address phase
   logic [7:0] ap_addr;
   logic [1:0] pin_meta; // sdo, err_n first stage
   logic [1:0] pin_sync;
   logic [`FDS_FRAME_BITS-1:0] frame; // Outgoing frame, MSB first
   logic [63:0] capture; // Last 64 bits seen on sdo
   fds_pkg::fds_host_state_t h_state;
   logic [2:0] phase_cnt;
   logic [8:0] bit_cnt;
   logic busy;
   logic start;

   assign hresp = 1'b0;
   assign hreadyout = 1'b1; // Zero wait states
   assign busy = (h_state != fds_pkg::FDS_H_IDLE);
   // A command write while busy is dropped
   assign start = ap_write && (ap_addr == `FDS_REG_CMD) && !busy;

   // AHB address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_write <= 1'b0;
         ap_addr <= 8'h00;
      end else if (hready) begin
         ap_write <= hsel && htrans[1] && hwrite;
         ap_addr <= haddr[7:0];
      end
   end

   // Read data registered at the address phase, so it stands through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         // Unmapped offsets read zero
         unique case (haddr[7:0])
            `FDS_REG_STATUS: hrdata <= {30'h00000000, ~pin_sync[1], busy};
            `FDS_REG_RD_LO: hrdata <= capture[31:0];
            `FDS_REG_RD_HI: hrdata <= capture[63:32];
            default: hrdata <= 32'h00000000;
         endcase
      end else begin
         // Idle bus reads zero
         hrdata <= 32'h00000000;
      end
   end

   // Pin synchroniser for device outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= 2'b10;
         pin_sync <= 2'b10;
      end else begin
         pin_meta <= {link.err_n, link.sdo};
         pin_sync <= pin_meta;
      end
   end

   // Frame sequencer: each bit a low then a high phase, then latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         h_state <= fds_pkg::FDS_H_IDLE;
         phase_cnt <= 3'h0;
         bit_cnt <= 9'h000;
         frame <= '0;
         capture <= 64'h0;
         link.sck <= 1'b0;
         link.sdi <= 1'b0;
         link.latch <= 1'b0;
      end else begin
         unique case (h_state)
            fds_pkg::FDS_H_IDLE: begin
               if (start) begin
                  // Command in the top bits, config bits at the bottom
                  frame <= {hwdata[11:0], {(`FDS_FRAME_BITS-14){1'b0}}, hwdata[13:12]};
                  bit_cnt <= 9'(`FDS_FRAME_BITS - 1);
                  phase_cnt <= 3'(`FDS_HOST_PHASE_CYC - 1);
                  h_state <= fds_pkg::FDS_H_LOW;
               end
            end
            fds_pkg::FDS_H_LOW: begin
               link.sck <= 1'b0;
               link.sdi <= frame[`FDS_FRAME_BITS-1];
               if (phase_cnt == 3'h0) begin
                  // Sample sdo just before the rise that shifts it on
                  capture <= {capture[62:0], pin_sync[0]};
                  frame <= {frame[`FDS_FRAME_BITS-2:0], 1'b0};
                  link.sck <= 1'b1;
                  phase_cnt <= 3'(`FDS_HOST_PHASE_CYC - 1);
                  h_state <= fds_pkg::FDS_H_HIGH;
               end else begin
                  phase_cnt <= phase_cnt - 3'h1;
               end
            end
            fds_pkg::FDS_H_HIGH: begin
               if (phase_cnt != 3'h0) begin
                  phase_cnt <= phase_cnt - 3'h1;
               end else if (bit_cnt == 9'h000) begin
                  link.sck <= 1'b0;
                  link.latch <= 1'b1;
                  phase_cnt <= 3'(`FDS_HOST_PHASE_CYC - 1);
                  h_state <= fds_pkg::FDS_H_LATCH;
               end else begin
                  bit_cnt <= bit_cnt - 9'h001;
                  phase_cnt <= 3'(`FDS_HOST_PHASE_CYC - 1);
                  h_state <= fds_pkg::FDS_H_LOW;
               end
            end
            fds_pkg::FDS_H_LATCH: begin
               if (phase_cnt == 3'h0) begin
                  link.latch <= 1'b0;
                  h_state <= fds_pkg::FDS_H_IDLE;
               end else begin
                  phase_cnt <= phase_cnt - 3'h1;
               end
            end
         endcase
      end
   end
endmodule

// File: hw/fds_if.sv
`timescale 1ns/1ps
interface fds_if;
   logic sck;      // Shift clock, host driven
   logic sdi;      // Data into device
   logic sdo;      // Data out of device
   logic latch;    // Frame latch, host driven
   logic err_o;    // Device fault pulldown level
   logic err_oe_n; // Low while device pulls the line
   logic err_n;    // Resolved open-drain line with pullup

   // Open drain: released line floats high
   assign err_n = err_oe_n ? 1'b1 : err_o;

   modport device (input sck, input sdi, input latch, output sdo, output err_o, output err_oe_n);
   modport host (output sck, output sdi, output latch, input sdo, input err_n);
endinterface

// File: hw/fds_pkg.sv
package fds_pkg;
   // Device short check sequencer
   typedef enum logic [1:0] {
      FDS_SC_IDLE = 2'b00,
      FDS_SC_RUN = 2'b01,
      FDS_SC_LATCH = 2'b11
   } fds_sc_state_t;

   // Host frame sequencer
   typedef enum logic [1:0] {
      FDS_H_IDLE = 2'b00,
      FDS_H_LOW = 2'b01,
      FDS_H_HIGH = 2'b11,
      FDS_H_LATCH = 2'b10
   } fds_host_state_t;
endpackage

// File: hw/fds_regs.svh
`ifndef FDS_REGS_SVH
`define FDS_REGS_SVH

// Link frame geometry
`define FDS_FRAME_BITS 288
`define FDS_CMD_MSB 287
`define FDS_CMD_LSB 276

// Command codes carried in the top twelve frame bits
`define FDS_CMD_CONFIG 12'h000
`define FDS_CMD_FAULT_CLEAR 12'ha53
`define FDS_CMD_SHORT_CHECK 12'ha56
`define FDS_CMD_STATUS_READ 12'ha5b

// Configuration bits inside a config frame
`define FDS_CFG_CUR_BIT 0
`define FDS_CFG_TIME_BIT 1

// Short check result codes
`define FDS_CODE_NONE 3'h0
`define FDS_CODE_PASS 3'h3
`define FDS_CODE_FAIL 3'h6

// Status word layout, low bits of the shift register
`define FDS_ST_RESULT_LSB 0
`define FDS_ST_CODE_LSB 24
`define FDS_ST_REF_SHORT_BIT 27
`define FDS_ST_REF_OPEN_BIT 28
`define FDS_ST_WARN_BIT 29
`define FDS_ST_THERM_BIT 30
`define FDS_ST_WIDTH 34

// Reset values
`define FDS_RESULT_RESET 24'h000000
`define FDS_CODE_RESET 3'h0

// Timing
`define FDS_CLK_MHZ 25
`define FDS_SC_TIME_SHORT_US 10
`define FDS_SC_TIME_LONG_US 20
`define FDS_SC_CYC_SHORT (`FDS_SC_TIME_SHORT_US * `FDS_CLK_MHZ)
`define FDS_SC_CYC_LONG (`FDS_SC_TIME_LONG_US * `FDS_CLK_MHZ)
`define FDS_HOST_PHASE_CYC 4

// Host register offsets
`define FDS_REG_CMD 8'h00
`define FDS_REG_STATUS 8'h04
`define FDS_REG_RD_LO 8'h08
`define FDS_REG_RD_HI 8'h0c

`endif

// File: tb/fds_asserts.sv
`timescale 1ns/1ps
// Watches the fault line, link strobes and device status outputs
module fds_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sck,
   input wire logic latch,
   input wire logic err_o,
   input wire logic err_oe_n,
   input wire logic err_n,
   input wire logic reference_current_pin_low,
   input wire logic reference_current_pin_high,
   input wire logic thermal_warn,
   input wire logic thermal_shutdown,
   input wire logic outputs_enable,
   input wire logic current_default,
   input wire logic short_test_active,
   input wire logic short_test_current_sel
);
   logic latch_q; // Latch one cycle late
   logic [3:0] lat_age; // Cycles since latch rose, saturating
   logic [9:0] act_len; // Cycles of the running check

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Age of the last frame latch; a flag may only drop just after one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_q <= 1'b0;
         lat_age <= 4'hf;
      end else begin
         latch_q <= latch;
         if (latch && !latch_q) begin
            lat_age <= 4'h0;
         end else if (lat_age != 4'hf) begin
            lat_age <= lat_age + 4'h1;
         end
      end
   end

   // Length of the check window, cleared while no check runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_len <= 10'h000;
      end else if (short_test_active) begin
         act_len <= act_len + 10'h001;
      end else begin
         act_len <= 10'h000;
      end
   end

   a_fault_line_low: assert property (!err_oe_n |-> !err_n && !err_o)
      else $error("fault line not low while pulled");
   a_warn_pulls_line: assert property ($rose(thermal_warn) |-> ##[1:5] !err_oe_n)
      else $error("warning did not pull fault line");
   a_ref_pulls_line: assert property ($rose(reference_current_pin_low || reference_current_pin_high) |-> ##[1:5] !err_oe_n)
      else $error("reference fault did not pull fault line");
   a_shutdown_reacts: assert property ($rose(thermal_shutdown)
      |-> ##[1:5] (!err_oe_n && !outputs_enable))
      else $error("shutdown not reported or outputs left on");
   a_shutdown_off: assert property (thermal_shutdown [*4] |-> !outputs_enable)
      else $error("outputs on during shutdown");
   a_resume_auto: assert property (!thermal_shutdown [*5] |-> outputs_enable)
      else $error("outputs did not resume");
   a_ref_default: assert property ((reference_current_pin_low || reference_current_pin_high) [*4] |-> current_default)
      else $error("default current not forced");
   a_ref_restore: assert property (!(reference_current_pin_low || reference_current_pin_high) [*4] |-> !current_default)
      else $error("default current kept after fault gone");
   a_flag_clear_latch: assert property ($rose(err_oe_n) |-> lat_age <= 4'ha)
      else $error("fault line released without a clear frame");
   a_check_time: assert property ($fell(short_test_active)
      |-> act_len inside {[248:252], [498:502]})
      else $error("check interval length wrong");
   a_cur_steady: assert property (short_test_active && $past(short_test_active)
      |-> $stable(short_test_current_sel))
      else $error("test current changed mid check");

   cover property ($fell(short_test_active));
   cover property (latch && !sck);
   cover property ($rose(err_oe_n));
   cover property (thermal_shutdown ##1 !thermal_shutdown);
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "fds_regs.svh"
module testbench;
   logic hclk; // Bus and device clock
   logic hresetn; // Async reset, active low
   logic hsel; // Slave select
   logic [31:0] haddr; // Address phase address
   logic [1:0] htrans; // Transfer kind
   logic hwrite; // Write strobe
   logic [2:0] hsize; // Always a word
   logic [31:0] hwdata; // Write data
   logic [31:0] hrdata; // Read data
   logic [31:0] hrdata_s; // Read data taken at the edge
   logic hreadyout; // Slave ready, also bus ready
   logic hresp; // Slave response
   logic [23:0] short_detect; // Neighbour short levels
   logic reference_current_pin_low, reference_current_pin_high, thermal_warn, thermal_shutdown; // Fault levels
   logic outputs_enable, current_default, short_test_active, short_test_current_sel;
   int bad_count; // Mismatches
   int checks; // Comparisons
   logic [31:0] st; // Scratch word

   fds_if link_if();

   fds_device i_fds_device (.hclk(hclk), .hresetn(hresetn), .link(link_if),
      .short_detect(short_detect), .reference_current_pin_low(reference_current_pin_low), .reference_current_pin_high(reference_current_pin_high),
      .thermal_warn(thermal_warn), .thermal_shutdown(thermal_shutdown),
      .outputs_enable(outputs_enable), .current_default(current_default),
      .short_test_active(short_test_active), .short_test_current_sel(short_test_current_sel));

   fds_host i_fds_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link_if));

   fds_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .sck(link_if.sck),
      .latch(link_if.latch), .err_o(link_if.err_o), .err_oe_n(link_if.err_oe_n),
      .err_n(link_if.err_n), .reference_current_pin_low(reference_current_pin_low), .reference_current_pin_high(reference_current_pin_high),
      .thermal_warn(thermal_warn), .thermal_shutdown(thermal_shutdown),
      .outputs_enable(outputs_enable), .current_default(current_default),
      .short_test_active(short_test_active), .short_test_current_sel(short_test_current_sel));

   // Clock, 40 ns period
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Read data is taken at the closing edge, before it can move
   always @(posedge hclk) begin
      hrdata_s <= hrdata;
   end

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task test_done;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Let n edges pass, then step off the edge
   task cyc(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   // One single word transfer; waits on ready, never on a fixed count
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      #1;
      rd = hrdata_s;
   endtask

   // One link frame: command write, then wait for busy to drop
   task send(input logic [11:0] code, input logic [1:0] cfg);
      logic [31:0] s;
      int n;
      ahb(1'b1, 32'h00000000, {18'h0, cfg, code}, s);
      n = 0;
      do begin
         ahb(1'b0, 32'h00000004, 32'h0, s);
         n++;
      end while (s[0] !== 1'b0 && n < 2000);
      chk("busy clears", 32'(n < 2000), 32'h1);
      cyc(8);
   endtask

   // Status comes out on the frame after the one that loads it
   task status(output logic [31:0] lo);
      send(`FDS_CMD_STATUS_READ, 2'b00);
      send(`FDS_CMD_STATUS_READ, 2'b00);
      ahb(1'b0, 32'h00000008, 32'h0, lo);
   endtask

   task chk_line(input logic exp);
      chk("fault line", 32'(link_if.err_n), 32'(exp));
   endtask

   // Configure, start a check and time its window
   task run_check(input logic [1:0] cfg, input int exp_len, input logic exp_cur);
      int n;
      int len;
      send(`FDS_CMD_CONFIG, cfg);
      fork
         // Started after the configuration frame, while the branch below times its window
         send(`FDS_CMD_SHORT_CHECK, 2'b00);
         begin
            n = 0;
            while (short_test_active !== 1'b1 && n < 4000) begin
               cyc(1);
               n++;
            end
            chk("test current", 32'(short_test_current_sel), 32'(exp_cur));
            len = 0;
            while (short_test_active === 1'b1 && len < 600) begin
               cyc(1);
               len++;
            end
            chk("check length", 32'(len >= exp_len - 2 && len <= exp_len + 2), 32'h1);
         end
      join
   endtask

   task t_reset;
      status(st);
      chk("reset status", st, 32'h0);
      chk_line(1'b1);
      chk("outputs on", 32'(outputs_enable), 32'h1);
      ahb(1'b0, 32'h00000010, 32'h0, st);
      chk("unmapped read", st, 32'h0);
      chk("response okay", 32'(hresp), 32'h0);
   endtask

   task t_pass;
      run_check(2'b01, `FDS_SC_CYC_SHORT, 1'b1);
      status(st);
      chk("pass status", st, 32'h03000000);
      // Any other code would mean the checking circuit itself is broken
      chk("code known", 32'(st[26:24] == `FDS_CODE_PASS
         || st[26:24] == `FDS_CODE_FAIL), 32'h1);
      ahb(1'b0, 32'h0000000c, 32'h0, st);
      chk("status high word", st, 32'h0);
      chk_line(1'b1);
   endtask

   // Red 0 and 1, blue 0 and 7 shorted; clear must not drop it while present
   task t_fail;
      short_detect <= 24'h810003;
      run_check(2'b10, `FDS_SC_CYC_LONG, 1'b0);
      status(st);
      chk("fail status", st, 32'h06810003);
      chk_line(1'b0);
      ahb(1'b0, 32'h00000004, 32'h0, st);
      chk("host sees fault", st, 32'h00000002);
      send(`FDS_CMD_FAULT_CLEAR, 2'b00);
      chk_line(1'b0);
      short_detect <= 24'h000000;
      send(`FDS_CMD_FAULT_CLEAR, 2'b00);
      status(st);
      chk("cleared status", st, 32'h0);
      chk_line(1'b1);
   endtask

   task t_ref;
      reference_current_pin_low <= 1'b1;
      cyc(10);
      chk("default current", 32'(current_default), 32'h1);
      chk_line(1'b0);
      status(st);
      chk("open only", st, 32'h10000000);
      reference_current_pin_low <= 1'b0;
      cyc(6);
      chk("current restored", 32'(current_default), 32'h0);
      chk_line(1'b0);
      reference_current_pin_high <= 1'b1;
      status(st);
      chk("short added", st, 32'h18000000);
      reference_current_pin_high <= 1'b0;
      send(`FDS_CMD_FAULT_CLEAR, 2'b00);
      status(st);
      chk("ref cleared", st, 32'h0);
   endtask

   // Link keeps working in shutdown; flag survives a clear while hot
   task t_thermal;
      thermal_warn <= 1'b1;
      thermal_shutdown <= 1'b1;
      cyc(10);
      chk("outputs off", 32'(outputs_enable), 32'h0);
      status(st);
      chk("thermal status", st, 32'h60000000);
      send(`FDS_CMD_FAULT_CLEAR, 2'b00);
      chk_line(1'b0);
      thermal_shutdown <= 1'b0;
      thermal_warn <= 1'b0;
      cyc(6);
      chk("outputs back", 32'(outputs_enable), 32'h1);
      chk_line(1'b0);
      send(`FDS_CMD_FAULT_CLEAR, 2'b00);
      status(st);
      chk("thermal cleared", st, 32'h0);
      chk_line(1'b1);
   endtask

   // Main sequence
   initial begin
      bad_count = 0;
      checks = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      short_detect = 24'h000000;
      reference_current_pin_low = 1'b0;
      reference_current_pin_high = 1'b0;
      thermal_warn = 1'b0;
      thermal_shutdown = 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(4);
      t_reset();
      t_pass();
      t_fail();
      t_ref();
      t_thermal();
      test_done();
   end

   // About 27 frames of some 2400 cycles each fit well inside this
   initial begin
      repeat (90000) @(posedge hclk);
      bad_count++;
      $display("watchdog expired");
      test_done();
   end
endmodule
